// file: core/lsr_integ_timer.sv
// Integration cycle counter and internal period timer.
// Assumes osc_tick is a one-cycle pulse per internal oscillator period.
`timescale 1ns/1ps
`default_nettype none
`include "lsr_params.svh"

module lsr_integ_timer
   import lsr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        osc_tick,
   input  wire logic        run,
   input  wire logic        restart,
   input  wire logic        internal,
   input  wire logic        diff,
   output logic [15:0]      cnt_now,
   output logic             phase,
   output logic             int_end
);

   logic [15:0] cnt_q;
   logic        phase_q;
   logic        last_tick;

   // ----------------------------------------
   // Cycle counter
   // ----------------------------------------
   assign last_tick = osc_tick && run && internal && (cnt_q == `LSR_INT_LAST);
   assign int_end   = last_tick && !(diff && !phase_q) && !restart;
   // Value as it stands after this cycle's tick, for capture at a period end
   assign cnt_now   = cnt_q + ((osc_tick && run) ? `LSR_CNT_ONE : `LSR_CNT_ZERO);
   assign phase     = phase_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= `LSR_CNT_ZERO;
      end else if (restart || !run) begin
         cnt_q <= `LSR_CNT_ZERO;
      end else if (last_tick) begin
         cnt_q <= `LSR_CNT_ZERO;
      end else if (osc_tick) begin
         // Wraps past 65,535; the host keeps periods shorter
         cnt_q <= cnt_q + `LSR_CNT_ONE;
      end
   end

   // Internal differential: diode 2 half first, then diode 1 half; external differential stays on diode 2
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         phase_q <= 1'b0;
      end else if (restart || !run) begin
         phase_q <= 1'b0;
      end else if (last_tick && diff) begin
         phase_q <= !phase_q;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_tick_adv;
      @(posedge clk) disable iff (!rst_b)
      osc_tick && run && !restart && !last_tick |=> cnt_q == $past(cnt_q) + `LSR_CNT_ONE;
   endproperty
   a_tick_adv: assert property (p_tick_adv) else $error("counter did not advance on tick");

   property p_int_len;
      @(posedge clk) disable iff (!rst_b)
      int_end && internal |-> cnt_now == `LSR_INT_CYCLES;
   endproperty
   a_int_len: assert property (p_int_len) else $error("internal period not 32768 cycles");

   property p_restart;
      @(posedge clk) disable iff (!rst_b)
      restart |=> cnt_q == `LSR_CNT_ZERO && !phase_q;
   endproperty
   a_restart: assert property (p_restart) else $error("counter not cleared on restart");

endmodule
`default_nettype wire

// file: core/lsr_params.svh
// Constants of the light sensor result readout: command codes, bus address,
// byte positions and integration timing.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef LSR_PARAMS_SVH
`define LSR_PARAMS_SVH

// ----------------------------------------
// Command codes
// ----------------------------------------
`define LSR_CMD_INT_D1     8'h00
`define LSR_CMD_INT_D2     8'h04
`define LSR_CMD_INT_DIFF   8'h08
`define LSR_CMD_EXT_D1     8'h30
`define LSR_CMD_EXT_D2     8'h34
`define LSR_CMD_EXT_DIFF   8'h38
`define LSR_CMD_PWR_DOWN   8'h8C
`define LSR_CMD_ADC_RESET  8'h0C

// ----------------------------------------
// Bus address and result byte positions
// ----------------------------------------
`define LSR_BUS_ADDR       7'h44
`define LSR_IDX_RES_LOW    3'h0
`define LSR_IDX_RES_HIGH   3'h1
`define LSR_IDX_CNT_LOW    3'h2
`define LSR_IDX_CNT_HIGH   3'h3
`define LSR_BYTES_INTERNAL 3'h2
`define LSR_BYTES_EXTERNAL 3'h4
`define LSR_IDLE_BYTE      8'hFF

// ----------------------------------------
// Integration timing
// ----------------------------------------
`define LSR_OSC_RATE_HZ    327600
`define LSR_INT_PERIOD_MS  100
`define LSR_DIFF_PERIOD_MS 200
`define LSR_INT_LAST       16'h7FFF
`define LSR_INT_CYCLES     16'h8000
`define LSR_CNT_ZERO       16'h0000
`define LSR_CNT_ONE        16'h0001

`endif

// file: core/lsr_pkg.sv
// Types of the light sensor result readout.
// Assumes lsr_params.svh for the figures that go with these types.
package lsr_pkg;

   // ----------------------------------------
   // Operating modes
   // ----------------------------------------
   typedef enum logic [2:0] {
      LSR_IDLE,
      LSR_INT_D1,
      LSR_INT_D2,
      LSR_INT_DIFF,
      LSR_EXT_D1,
      LSR_EXT_D2,
      LSR_EXT_DIFF
   } lsr_mode_t;

   // ----------------------------------------
   // Read side carriers
   // ----------------------------------------
   typedef struct packed {
      logic       start;
      logic [6:0] addr;
      logic       next;
   } lsr_rd_req_t;

   typedef struct packed {
      logic       valid;
      logic       ack;
      logic [7:0] data;
   } lsr_rd_rsp_t;

endpackage

// file: core/lsr_readout.sv
// Result readout and integration timing of the light sensor.
// Assumes an external bus engine that decodes start, address and byte
// requests, and a converter that returns each result as a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
`include "lsr_params.svh"

// Notes on behaviour
// - Result bytes unaddressed, always read ascending
// - Bytes one and two: result, low first
// - Bytes three and four: count, low first
// - Each oscillator cycle advances 16-bit counter
// - Period end captures counter into count bytes; code holds it and loads them at the next conversion
// - Internal modes refuse bytes after result pair
// - Internal period ends after 32,768 cycles
// - Nominal oscillator 327.6kHz gives 100ms period
// - External period runs command to command
// - External count follows elapsed time, 16-bit
// - Oscillator runs alike in both timings
// - External command restarts integration and counter
// - Result format follows latest mode command
// - Codes 30H/34H/38H; repeat closes and reopens
// - Codes 00H/04H/08H; differential doubles period
// - Early read returns previous stored result
// - Reads use fixed address 44 hex
module lsr_readout
   import lsr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        osc_tick,
   input  wire logic        cmd_valid,
   input  wire logic [7:0]  cmd_code,
   input  wire logic        conv_valid,
   input  wire logic [15:0] conv_data,
   input  wire lsr_rd_req_t rd_req,
   output lsr_rd_rsp_t      rd_rsp,
   output logic             integ_end,
   output logic             diode_sel,
   output logic             result_signed,
   output lsr_mode_t        mode
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic mode_is_ext(input lsr_mode_t m);
      mode_is_ext = (m == LSR_EXT_D1) || (m == LSR_EXT_D2) || (m == LSR_EXT_DIFF);
   endfunction

   function automatic logic mode_is_diff(input lsr_mode_t m);
      mode_is_diff = (m == LSR_INT_DIFF) || (m == LSR_EXT_DIFF);
   endfunction

   function automatic logic [7:0] pick_byte(input logic [2:0]  idx,
                                            input logic [15:0] res,
                                            input logic [15:0] cnt);
      unique case (idx)
         `LSR_IDX_RES_LOW:  pick_byte = res[7:0];
         `LSR_IDX_RES_HIGH: pick_byte = res[15:8];
         `LSR_IDX_CNT_LOW:  pick_byte = cnt[7:0];
         `LSR_IDX_CNT_HIGH: pick_byte = cnt[15:8];
         default:           pick_byte = `LSR_IDLE_BYTE;
      endcase
   endfunction

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   lsr_mode_t   mode_q;
   lsr_mode_t   cmd_mode;
   logic        cmd_is_mode;
   logic        cmd_pwr_down;
   logic        cmd_adc_reset;
   logic        ext_end;
   logic        restart;

   always_comb begin
      cmd_mode      = mode_q;
      cmd_is_mode   = 1'b1;
      cmd_pwr_down  = 1'b0;
      cmd_adc_reset = 1'b0;
      unique case (cmd_code)
         `LSR_CMD_INT_D1:    cmd_mode = LSR_INT_D1;
         `LSR_CMD_INT_D2:    cmd_mode = LSR_INT_D2;
         `LSR_CMD_INT_DIFF:  cmd_mode = LSR_INT_DIFF;
         `LSR_CMD_EXT_D1:    cmd_mode = LSR_EXT_D1;
         `LSR_CMD_EXT_D2:    cmd_mode = LSR_EXT_D2;
         `LSR_CMD_EXT_DIFF:  cmd_mode = LSR_EXT_DIFF;
         `LSR_CMD_PWR_DOWN: begin
            cmd_mode     = LSR_IDLE;
            cmd_pwr_down = 1'b1;
         end
         `LSR_CMD_ADC_RESET: begin
            cmd_is_mode   = 1'b0;
            cmd_adc_reset = 1'b1;
         end
         default:            cmd_is_mode = 1'b0;
      endcase
   end

   // A repeated external code closes the running period; a new mode only opens one
   assign ext_end = cmd_valid && cmd_is_mode && mode_is_ext(cmd_mode)
                    && (cmd_mode == mode_q);
   assign restart = cmd_valid && (cmd_is_mode || cmd_adc_reset || cmd_pwr_down);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_q <= LSR_IDLE;
      end else if (cmd_valid && cmd_is_mode) begin
         mode_q <= cmd_mode;
      end
   end

   // ----------------------------------------
   // Integration timer
   // ----------------------------------------
   logic [15:0] cnt_now;
   logic        phase;
   logic        tmr_end;
   logic        period_end;

   // Oscillator rate comes from the resistor alone; both timings share one tick
   lsr_integ_timer u_timer (
      .clk      (clk),
      .rst_b    (rst_b),
      .osc_tick (osc_tick),
      .run      (mode_q != LSR_IDLE),
      .restart  (restart),
      .internal (!mode_is_ext(mode_q)),
      .diff     (mode_is_diff(mode_q)),
      .cnt_now  (cnt_now),
      .phase    (phase),
      .int_end  (tmr_end)
   );

   assign period_end = tmr_end || ext_end;

   // ----------------------------------------
   // Capture and result update
   // ----------------------------------------
   logic [15:0] pend_cnt_q;
   logic        pend_signed_q;
   logic [15:0] res_q;
   logic [15:0] cnt_q;
   logic        signed_q;
   logic        integ_end_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pend_cnt_q    <= `LSR_CNT_ZERO;
         pend_signed_q <= 1'b0;
      end else if (period_end) begin
         pend_cnt_q    <= cnt_now;
         pend_signed_q <= mode_is_diff(mode_q);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         integ_end_q <= 1'b0;
      end else begin
         integ_end_q <= period_end;
      end
   end

   // Result and its count move in one edge, so a snapshot never mixes them
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         res_q    <= `LSR_CNT_ZERO;
         cnt_q    <= `LSR_CNT_ZERO;
         signed_q <= 1'b0;
      end else if (conv_valid) begin
         res_q    <= conv_data;
         cnt_q    <= pend_cnt_q;
         signed_q <= pend_signed_q;
      end
   end

   // ----------------------------------------
   // Byte readout
   // ----------------------------------------
   logic [15:0] snap_res_q;
   logic [15:0] snap_cnt_q;
   logic [2:0]  idx_q;
   logic        open_q;
   logic        addr_hit;
   logic [2:0]  offered;
   lsr_rd_rsp_t rsp_q;

   assign addr_hit = rd_req.start && (rd_req.addr == `LSR_BUS_ADDR);
   assign offered  = mode_is_ext(mode_q) ? `LSR_BYTES_EXTERNAL : `LSR_BYTES_INTERNAL;

   // Snapshot at the start of a read; a conversion landing mid-read waits
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         snap_res_q <= `LSR_CNT_ZERO;
         snap_cnt_q <= `LSR_CNT_ZERO;
      end else if (addr_hit) begin
         snap_res_q <= res_q;
         snap_cnt_q <= cnt_q;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         open_q <= 1'b0;
      end else if (rd_req.start) begin
         open_q <= addr_hit;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         idx_q <= `LSR_IDX_RES_LOW;
      end else if (addr_hit) begin
         idx_q <= `LSR_IDX_RES_LOW;
      end else if (rd_req.next && open_q && (idx_q != `LSR_BYTES_EXTERNAL)) begin
         idx_q <= idx_q + 3'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rsp_q <= '0;
      end else begin
         rsp_q.valid <= rd_req.next && open_q && !rd_req.start;
         if (rd_req.next && open_q && !rd_req.start) begin
            rsp_q.ack  <= idx_q < offered;
            rsp_q.data <= (idx_q < offered) ? pick_byte(idx_q, snap_res_q, snap_cnt_q)
                                            : `LSR_IDLE_BYTE;
         end
      end
   end

   assign rd_rsp        = rsp_q;
   assign integ_end     = integ_end_q;
   assign diode_sel     = mode_is_diff(mode_q) ? !phase
                          : ((mode_q == LSR_INT_D2) || (mode_q == LSR_EXT_D2));
   assign result_signed = signed_q;
   assign mode          = mode_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_order;
      @(posedge clk) disable iff (!rst_b)
      rd_req.next && open_q && !rd_req.start && idx_q == `LSR_IDX_RES_LOW
         |=> idx_q == `LSR_IDX_RES_HIGH;
   endproperty
   a_order: assert property (p_order) else $error("byte index did not step");

   property p_res_bytes;
      @(posedge clk) disable iff (!rst_b)
      rd_req.next && open_q && !rd_req.start && idx_q == `LSR_IDX_RES_HIGH
         |=> rsp_q.valid && rsp_q.ack && rsp_q.data == snap_res_q[15:8];
   endproperty
   a_res_bytes: assert property (p_res_bytes) else $error("result high byte wrong");

   property p_cnt_bytes;
      @(posedge clk) disable iff (!rst_b)
      rd_req.next && open_q && !rd_req.start && idx_q == `LSR_IDX_CNT_LOW && mode_is_ext(mode_q)
         |=> rsp_q.ack && rsp_q.data == snap_cnt_q[7:0];
   endproperty
   a_cnt_bytes: assert property (p_cnt_bytes) else $error("count low byte wrong");

   property p_nak_internal;
      @(posedge clk) disable iff (!rst_b)
      rd_req.next && open_q && !rd_req.start && idx_q >= `LSR_BYTES_INTERNAL
         && !mode_is_ext(mode_q) |=> rsp_q.valid && !rsp_q.ack;
   endproperty
   a_nak_internal: assert property (p_nak_internal) else $error("byte acked past result");

   property p_capture;
      @(posedge clk) disable iff (!rst_b)
      period_end |=> pend_cnt_q == $past(cnt_now) && integ_end;
   endproperty
   a_capture: assert property (p_capture) else $error("count not captured at period end");

   property p_together;
      @(posedge clk) disable iff (!rst_b)
      conv_valid |=> res_q == $past(conv_data) && cnt_q == $past(pend_cnt_q);
   endproperty
   a_together: assert property (p_together) else $error("result and count split");

   property p_hold;
      @(posedge clk) disable iff (!rst_b)
      !conv_valid |=> $stable(res_q) && $stable(cnt_q);
   endproperty
   a_hold: assert property (p_hold) else $error("result changed without conversion");

   property p_ext_end;
      @(posedge clk) disable iff (!rst_b)
      cmd_valid && cmd_code == `LSR_CMD_EXT_D1 && mode_q == LSR_EXT_D1 |=> integ_end;
   endproperty
   a_ext_end: assert property (p_ext_end) else $error("repeated code did not end period");

   property p_mode;
      @(posedge clk) disable iff (!rst_b)
      cmd_valid && cmd_code == `LSR_CMD_INT_DIFF |=> mode_q == LSR_INT_DIFF;
   endproperty
   a_mode: assert property (p_mode) else $error("mode not taken from command");

endmodule
`default_nettype wire

// file: verification/lsr_host_model.sv
// Bus host model: sends command bytes and addressed reads to the readout.
// Assumes the bench calls its tasks just after a rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
`include "lsr_params.svh"

module lsr_host_model
   import lsr_pkg::*;
(
   input  wire logic        clk,
   output var logic         cmd_valid,
   output var logic [7:0]   cmd_code,
   output var lsr_rd_req_t  rd_req,
   input  wire lsr_rd_rsp_t rd_rsp
);
   logic [7:0] got_data [8];
   logic       got_ack  [8];
   logic       got_vld  [8];

   initial begin
      cmd_valid = 1'b0;
      cmd_code  = 8'h00;
      rd_req    = '0;
   end

   // ----------------------------------------
   // Commands
   // ----------------------------------------
   // Released byte shows the inverse so stale data cannot pass
   task automatic send_cmd(input logic [7:0] code);
      cmd_valid <= 1'b1;
      cmd_code  <= code;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_code  <= ~code;
   endtask

   // ----------------------------------------
   // Reads, with random slack between bytes
   // ----------------------------------------
   task automatic read(input logic [6:0] addr, input int n);
      int gap;
      rd_req.start <= 1'b1;
      rd_req.addr  <= addr;
      @(posedge clk);
      rd_req.start <= 1'b0;
      rd_req.addr  <= ~addr;
      for (int i = 0; i < n; i++) begin
         gap = $urandom % 4;
         rd_req.next <= 1'b1;
         @(posedge clk);
         rd_req.next <= 1'b0;
         @(posedge clk);
         got_vld[i]  = rd_rsp.valid;
         got_ack[i]  = rd_rsp.ack;
         got_data[i] = rd_rsp.data;
         repeat (gap) @(posedge clk);
      end
   endtask
endmodule
`default_nettype wire

// file: verification/tb_light_sensor_result_readout.sv
// Self-checking bench for the result readout against a byte-queue model.
// Assumes lsr_host_model drives commands and reads; no other bus exists.
`timescale 1ns/1ps
`default_nettype none
`include "lsr_params.svh"

module tb_light_sensor_result_readout
   import lsr_pkg::*;
();
   logic        clk;
   logic        rst_b;
   logic        osc_tick;
   logic        cmd_valid;
   logic [7:0]  cmd_code;
   logic        conv_valid;
   logic [15:0] conv_data;
   lsr_rd_req_t rd_req;
   lsr_rd_rsp_t rd_rsp;
   logic        integ_end;
   logic        diode_sel;
   logic        result_signed;
   lsr_mode_t   mode;
   int          err_count;
   int          num_checks;
   int          cyc = 0;
   int          exp_res;
   int          exp_cnt;
   int          exp_q [$];
   // Unknown code and converter reset keep the mode; power-down idles
   logic [7:0]  cmd_tab [9] = '{8'h00, 8'h04, 8'h08, 8'h30, 8'h34, 8'h38, 8'h5B,
                                8'h0C, 8'h8C};
   lsr_mode_t   mode_tab [9] = '{LSR_INT_D1, LSR_INT_D2, LSR_INT_DIFF, LSR_EXT_D1,
                                 LSR_EXT_D2, LSR_EXT_DIFF, LSR_EXT_DIFF, LSR_EXT_DIFF,
                                 LSR_IDLE};

   always #20 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   lsr_readout dut (
      .clk           (clk),
      .rst_b         (rst_b),
      .osc_tick      (osc_tick),
      .cmd_valid     (cmd_valid),
      .cmd_code      (cmd_code),
      .conv_valid    (conv_valid),
      .conv_data     (conv_data),
      .rd_req        (rd_req),
      .rd_rsp        (rd_rsp),
      .integ_end     (integ_end),
      .diode_sel     (diode_sel),
      .result_signed (result_signed),
      .mode          (mode)
   );

   lsr_host_model host (
      .clk       (clk),
      .cmd_valid (cmd_valid),
      .cmd_code  (cmd_code),
      .rd_req    (rd_req),
      .rd_rsp    (rd_rsp)
   );

   // ----------------------------------------
   // Compare, verdict, bounded waits
   // ----------------------------------------
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s exp %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run();
      if (err_count == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic wait_end(input int bound);
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (integ_end !== 1'b1 && k < bound);
      if (integ_end !== 1'b1) begin
         chk("integ_end_wait", integ_end, 1'b1);
         complete_run();
      end
   endtask

   // Converter answer; stored result only moves after this pulse
   task automatic convert(input logic [15:0] d);
      conv_data  <= d;
      conv_valid <= 1'b1;
      @(posedge clk);
      conv_valid <= 1'b0;
      conv_data  <= ~d;
      @(posedge clk);
      exp_res = d;
   endtask

   task automatic read_chk(input int n, input int avail);
      host.read(`LSR_BUS_ADDR, n);
      exp_q = '{exp_res & 255, (exp_res >> 8) & 255, exp_cnt & 255, (exp_cnt >> 8) & 255};
      for (int i = 0; i < n; i++) begin
         chk("rd_valid", host.got_vld[i], 1'b1);
         chk("rd_ack", host.got_ack[i], i < avail);
         chk("rd_data", host.got_data[i], 16'((i < avail) ? exp_q[i] : `LSR_IDLE_BYTE));
      end
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [7:0] ccode;
      int         n;
      int         t;
      logic       b;
      clk        = 1'b0;
      rst_b      = 1'b0;
      osc_tick   = 1'b0;
      conv_valid = 1'b0;
      conv_data  = 16'h0000;
      err_count  = 0;
      num_checks = 0;
      exp_res    = 0;
      exp_cnt    = 0;
      void'($urandom(87));
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      chk("mode_reset", mode, LSR_IDLE);
      foreach (cmd_tab[i]) begin
         host.send_cmd(cmd_tab[i]);
         @(posedge clk);
         chk("mode", mode, mode_tab[i]);
         // Diode 2 for its own codes and for the first differential half
         if (!cmd_tab[i][7]) chk("diode_sel", diode_sel, cmd_tab[i][3] | cmd_tab[i][2]);
      end
      // Tick every cycle so the period length reads directly in clocks
      host.send_cmd(`LSR_CMD_INT_D1);
      osc_tick <= 1'b1;
      wait_end(40000);
      n = cyc;
      convert(16'($urandom));
      read_chk(3, 2);
      wait_end(40000);
      chk("int_period", 16'(cyc - n), `LSR_INT_CYCLES);
      osc_tick <= 1'b0;
      @(posedge clk);
      for (int c = 0; c < 3; c++) begin
         ccode = 8'h30 + 8'(c * 4);
         host.send_cmd(ccode);
         @(posedge clk);
         chk("integ_end_open", integ_end, 1'b0);
         for (int r = 0; r < 2; r++) begin
            n = 1 + $urandom % 300;
            t = 0;
            for (int k = 0; k < n; k++) begin
               b = 1'($urandom % 2);
               osc_tick <= b;
               t += b;
               @(posedge clk);
            end
            osc_tick <= 1'b0;
            @(posedge clk);
            host.send_cmd(ccode);
            @(posedge clk);
            chk("integ_end", integ_end, 1'b1);
            if (r > 0 || c > 0) read_chk(4, 4);
            exp_cnt = t;
            convert(16'($urandom));
            read_chk(5, 4);
            chk("result_signed", result_signed, c == 2);
         end
      end
      host.read(7'h45, 1);
      chk("rd_refused", host.got_vld[0], 1'b0);
      complete_run();
   end
endmodule
`default_nettype wire
